// ### tcco_defs.vh
// Purpose: Constants for the timer compare/capture/output block
// Assumes: AXI4-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses
`ifndef TCCO_DEFS_VH
`define TCCO_DEFS_VH
// Register byte offsets
`define TCCO_OFF_CTRL     12'h000
`define TCCO_OFF_OUTCTL   12'h004
`define TCCO_OFF_CMPA     12'h008
`define TCCO_OFF_CMPB     12'h00c
`define TCCO_OFF_CAPT     12'h010
`define TCCO_OFF_COUNT    12'h014
`define TCCO_OFF_STATUS   12'h018
`define TCCO_OFF_PRESC    12'h01c
// Control register fields
`define TCCO_CTRL_CE      0
`define TCCO_CTRL_EXT     1
`define TCCO_CTRL_MODL    2
`define TCCO_CTRL_MODH    3
`define TCCO_CTRL_CLRB    4
`define TCCO_CTRL_EDGE_LO 5
`define TCCO_CTRL_EDGE_HI 6
// Output control fields
`define TCCO_OC_ENA       0
`define TCCO_OC_LVA       1
`define TCCO_OC_ENB       2
`define TCCO_OC_LVB       3
`define TCCO_OC_OSA       4
`define TCCO_OC_OSB       5
`define TCCO_OC_TRIGA     6
`define TCCO_OC_TRIGB     7
// Status fields
`define TCCO_ST_OVF       0
`define TCCO_ST_EVT       1
`define TCCO_ST_RUN       2
// Edge modes
`define TCCO_EDGE_RISE    2'h0
`define TCCO_EDGE_FALL    2'h1
`define TCCO_EDGE_BOTH    2'h2
// Reset values
`define TCCO_RST_CTRL     7'h00
`define TCCO_RST_OUTCTL   6'h00
`define TCCO_RST_PRESC    12'h007
`define TCCO_RST_CMP      16'hffff
// AXI responses
`define TCCO_RESP_OKAY    2'h0
`define TCCO_RESP_SLVERR  2'h2
`endif

// ### tcco_edge_det.v
// Purpose: Synchronise a pin and detect selected edges
// Assumes: Pin is asynchronous to clk
// Notes:   First flop feeds only the second flop
module tcco_edge_det (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       pin,
  input  wire [1:0] edge_mode,
  output reg        edge_pulse
);
  reg sync1;
  reg sync2;
  reg last;

  // Two-flop synchroniser, then edge compare
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1      <= 1'b0;
      sync2      <= 1'b0;
      last       <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      last  <= sync2;
      case (edge_mode)
        2'h0:    edge_pulse <= sync2 & ~last;
        2'h1:    edge_pulse <= ~sync2 & last;
        default: edge_pulse <= sync2 ^ last;
      endcase
    end
  end
endmodule // tcco_edge_det

// ### tcco_timer.v
// Purpose: 16-bit timer with two compares, capture, two outputs
// Assumes: AXI4-Lite slave on clk; event pin asynchronous
// Notes:   No interrupt controller; match pulses go straight out
`include "tcco_defs.vh"
module tcco_timer (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        event_input_pin,
  output reg         timer_out_a,
  output reg         timer_out_b,
  output reg         match_a_irq,
  output reg         match_b_irq
);
  // Registers
  reg  [6:0]  timer_control_reg;
  reg  [5:0]  output_control_reg;
  reg  [15:0] compare_a;
  reg  [15:0] compare_b;
  reg  [15:0] capture_reg;
  reg  [15:0] count_register;
  reg  [11:0] presc_div;
  reg  [11:0] presc_cnt;
  reg         overflow_flag;
  reg         event_flag;
  reg         started;
  reg         pend_clear;
  reg         pend_trig_a;
  reg         pend_trig_b;
  reg         osa_act;
  reg         osb_act;
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        edge_detected_input;
  wire        count_enable_bit;
  wire        ext_mode;
  wire        clear_on_match_b;
  wire        mode_bit_low;
  wire        mode_bit_high;
  wire [1:0]  edge_mode_reg;
  wire        out_a_enable;
  wire        out_a_level;
  wire        out_b_enable;
  wire        out_b_level;
  wire        oneshot_a_select;
  wire        oneshot_b_select;
  wire        count_tick;
  wire        do_write;
  wire        wr_ctrl;
  wire        wr_outctl;
  wire        wr_status;
  wire        wr_hit;
  wire        rd_hit;
  wire [31:0] next_rdata;
  wire [15:0] next_count;
  wire        wrap;
  wire        hit_a;
  wire        hit_b;

  assign count_enable_bit = timer_control_reg[`TCCO_CTRL_CE];
  assign ext_mode         = timer_control_reg[`TCCO_CTRL_EXT];
  assign mode_bit_low     = timer_control_reg[`TCCO_CTRL_MODL];
  assign mode_bit_high    = timer_control_reg[`TCCO_CTRL_MODH];
  assign clear_on_match_b = timer_control_reg[`TCCO_CTRL_CLRB];
  assign edge_mode_reg    =
    timer_control_reg[`TCCO_CTRL_EDGE_HI:`TCCO_CTRL_EDGE_LO];
  assign out_a_enable     = output_control_reg[`TCCO_OC_ENA];
  assign out_a_level      = output_control_reg[`TCCO_OC_LVA];
  assign out_b_enable     = output_control_reg[`TCCO_OC_ENB];
  assign out_b_level      = output_control_reg[`TCCO_OC_LVB];
  assign oneshot_a_select = output_control_reg[`TCCO_OC_OSA];
  assign oneshot_b_select = output_control_reg[`TCCO_OC_OSB];

  tcco_edge_det u_edge (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pin        (event_input_pin),
    .edge_mode  (edge_mode_reg),
    .edge_pulse (edge_detected_input)
  );

  // AXI write: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit    = (aw_addr[11:5] == 7'h00) & (aw_addr[1:0] == 2'h0);
  assign wr_ctrl   = do_write & (aw_addr == `TCCO_OFF_CTRL) & w_strb[0];
  assign wr_outctl = do_write & (aw_addr == `TCCO_OFF_OUTCTL) & w_strb[0];
  assign wr_status = do_write & (aw_addr == `TCCO_OFF_STATUS) & w_strb[0];

  always @(posedge clk) begin
    if (sys_rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TCCO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TCCO_RESP_OKAY : `TCCO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; control bits and compares
  always @(posedge clk) begin
    if (sys_rst) begin
      timer_control_reg  <= `TCCO_RST_CTRL;
      output_control_reg <= `TCCO_RST_OUTCTL;
      compare_a          <= `TCCO_RST_CMP;
      compare_b          <= `TCCO_RST_CMP;
      presc_div          <= `TCCO_RST_PRESC;
    end else if (do_write) begin
      if (wr_ctrl)
        timer_control_reg <= w_data[6:0];
      if (wr_outctl)
        output_control_reg <= w_data[5:0];
      if (aw_addr == `TCCO_OFF_CMPA) begin
        if (w_strb[0]) compare_a[7:0]  <= w_data[7:0];
        if (w_strb[1]) compare_a[15:8] <= w_data[15:8];
      end
      if (aw_addr == `TCCO_OFF_CMPB) begin
        if (w_strb[0]) compare_b[7:0]  <= w_data[7:0];
        if (w_strb[1]) compare_b[15:8] <= w_data[15:8];
      end
      if (aw_addr == `TCCO_OFF_PRESC) begin
        if (w_strb[0]) presc_div[7:0]  <= w_data[7:0];
        if (w_strb[1]) presc_div[11:8] <= w_data[11:8];
      end
    end
  end

  // AXI read path
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_hit = (s_axi_araddr[11:5] == 7'h00) &
                  (s_axi_araddr[1:0] == 2'h0);
  assign next_rdata =
    (s_axi_araddr == `TCCO_OFF_CTRL)   ? {25'h0, timer_control_reg} :
    (s_axi_araddr == `TCCO_OFF_OUTCTL) ? {26'h0, output_control_reg} :
    (s_axi_araddr == `TCCO_OFF_CMPA)   ? {16'h0, compare_a} :
    (s_axi_araddr == `TCCO_OFF_CMPB)   ? {16'h0, compare_b} :
    (s_axi_araddr == `TCCO_OFF_CAPT)   ? {16'h0, capture_reg} :
    (s_axi_araddr == `TCCO_OFF_COUNT)  ? {16'h0, count_register} :
    (s_axi_araddr == `TCCO_OFF_STATUS) ?
      {29'h0, started, event_flag, overflow_flag} :
    (s_axi_araddr == `TCCO_OFF_PRESC)  ? {20'h0, presc_div} :
    32'h0000_0000;

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TCCO_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? `TCCO_RESP_OKAY : `TCCO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // external edges taken as ticks, rate kept low by software
  // Internal divider gives one tick every presc_div+1 clocks
  assign count_tick = count_enable_bit &
    (ext_mode ? edge_detected_input : (presc_cnt == presc_div));

  always @(posedge clk) begin
    if (sys_rst | ~count_enable_bit | (presc_cnt == presc_div))
      presc_cnt <= 12'h000;
    else
      presc_cnt <= presc_cnt + 12'h001;
  end

  assign wrap       = count_register == 16'hffff;
  assign next_count = count_register + 16'h0001;

  // Counter, start/clear/overflow control
  always @(posedge clk) begin
    if (sys_rst) begin
      count_register <= 16'h0000;
      started        <= 1'b0;
      pend_clear     <= 1'b0;
    end else if (~count_enable_bit) begin
      count_register <= 16'h0000;
      started        <= 1'b0;
      pend_clear     <= 1'b0;
    end else if (count_tick) begin
      // first tick loads zero; first edge only clears
      // rewrite of a set enable leaves started alone
      // pending clear applied on this tick
      started <= 1'b1;
      if (~started | pend_clear | wrap | (clear_on_match_b & hit_b))
        count_register <= 16'h0000;
      else
        count_register <= next_count;
      pend_clear <= 1'b0;
    end else if (started & clear_on_match_b & hit_b) begin
      // interval mode clear armed by match b
      pend_clear <= 1'b1;
    end
  end

  // equality against both compares, once per advance
  reg adv;
  always @(posedge clk) begin
    if (sys_rst)
      adv <= 1'b0;
    else
      adv <= count_tick;
  end
  assign hit_a = count_register == compare_a;
  assign hit_b = count_register == compare_b;

  always @(posedge clk) begin
    if (sys_rst) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      match_a_irq <= adv & started & count_enable_bit & hit_a;
      match_b_irq <= adv & started & count_enable_bit & hit_b;
    end
  end

  // Overflow sticky flag; set wins over software clear
  reg ovf_pulse;
  always @(posedge clk) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
      event_flag    <= 1'b0;
      ovf_pulse     <= 1'b0;
    end else begin
      // overflow sets flag, cleared by software only
      ovf_pulse <= count_tick & started & wrap & ~pend_clear;
      if (count_tick & started & wrap & ~pend_clear)
        overflow_flag <= 1'b1;
      else if (wr_status & w_data[`TCCO_ST_OVF])
        overflow_flag <= 1'b0;
      // event flag marks any valid edge
      if (edge_detected_input)
        event_flag <= 1'b1;
      else if (wr_status & w_data[`TCCO_ST_EVT])
        event_flag <= 1'b0;
    end
  end

  // capture on each valid edge while count enabled, held otherwise
  always @(posedge clk) begin
    if (sys_rst)
      capture_reg <= 16'h0000;
    else if (edge_detected_input & count_enable_bit)
      capture_reg <= count_register;
  end

  // Software one-shot triggers, held until the one-shot starts
  always @(posedge clk) begin
    if (sys_rst) begin
      pend_trig_a <= 1'b0;
      pend_trig_b <= 1'b0;
    end else begin
      pend_trig_a <= (wr_outctl & w_data[`TCCO_OC_TRIGA]) |
                     (pend_trig_a & ~osa_act);
      pend_trig_b <= (wr_outctl & w_data[`TCCO_OC_TRIGB]) |
                     (pend_trig_b & ~osb_act);
    end
  end

  // Output control: levels, modes and polarity
  // Active-high state per mode; level bit flips polarity
  always @(posedge clk) begin
    if (sys_rst) begin
      osa_act     <= 1'b0;
      osb_act     <= 1'b0;
      timer_out_a <= 1'b1;
      timer_out_b <= 1'b1;
    end else begin
      // disabled output fixed at inverse of level
      if (~out_a_enable) begin
        timer_out_a <= ~out_a_level;
        osa_act     <= 1'b0;
      end else if (oneshot_a_select) begin
        // one-shot: active from trigger to match a
        if (~osa_act & pend_trig_a) begin
          osa_act     <= 1'b1;
          timer_out_a <= out_a_level;
        end else if (~osa_act | match_a_irq) begin // Idle or done
          osa_act     <= 1'b0;
          timer_out_a <= ~out_a_level;
        end
      end else if (~count_enable_bit) begin
        // stopped toggle, PWM and PPG all go inactive
        if (mode_bit_low | mode_bit_high)
          timer_out_a <= ~out_a_level;
        else
          timer_out_a <= ~out_a_level;
      end else if (~mode_bit_high & ~mode_bit_low) begin
        if (match_a_irq)
          timer_out_a <= ~timer_out_a;
      end else begin
        // PWM/PPG: inactive at period start, active at match a
        // PPG period set by match b clear
        // Match and period start share one cycle of latency
        if (adv & started & hit_a)
          timer_out_a <= out_a_level;
        else if (adv & started & (count_register == 16'h0000))
          timer_out_a <= ~out_a_level;
      end
      if (~out_b_enable) begin
        timer_out_b <= ~out_b_level;
        osb_act     <= 1'b0;
      end else if (oneshot_b_select) begin
        // one-shot on output B ends at match b
        if (~osb_act & pend_trig_b) begin
          osb_act     <= 1'b1;
          timer_out_b <= out_b_level;
        end else if (~osb_act | match_b_irq) begin // Idle or done
          osb_act     <= 1'b0;
          timer_out_b <= ~out_b_level;
        end
      end else if (~count_enable_bit) begin
        timer_out_b <= ~out_b_level;
      end else if (mode_bit_high & ~mode_bit_low) begin
        // PWM on B, period is full count
        if (adv & started & hit_b)
          timer_out_b <= out_b_level;
        else if (ovf_pulse)
          timer_out_b <= ~out_b_level;
      end else if (match_b_irq) begin
        timer_out_b <= ~timer_out_b;
      end
    end
  end
endmodule // tcco_timer

// ### tcco_timer_asserts.sv
// Purpose: Port-level checker for the timer block
// Assumes: One clock domain, sync active-high reset
// Notes:   Bound to every instance of the timer top
module tcco_timer_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_out_a,
  input wire logic        timer_out_b,
  input wire logic        match_a_irq,
  input wire logic        match_b_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_irq_a_pulse: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a pulse longer than one cycle");
  a_irq_b_pulse: assert property (match_b_irq |=> !match_b_irq)
    else $error("match b pulse longer than one cycle");
  a_reset_levels: assert property ($fell(sys_rst) |->
    timer_out_a && timer_out_b && !match_a_irq && !match_b_irq)
    else $error("outputs not at reset levels");
  // Response channels drop after handshake
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |->
    ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_busy_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("request taken while response pending");
  a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule // tcco_timer_chk
bind tcco_timer tcco_timer_chk u_chk (.*);

// ### tcco_event_src.sv
// Purpose: Model of the source driving the event pin
// Assumes: Pin holds its last level between requests
// Notes:   Levels are held at least four clocks
module tcco_event_src (
  input  wire logic clk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle low from time zero
  initial pin = 1'b0;
  task automatic set_level(input logic lvl, input int hold);
    @(posedge clk);
    pin <= lvl;
    repeat (hold < 4 ? 4 : hold) @(posedge clk);
  endtask
endmodule // tcco_event_src

// ### tcco_timer_tb_top.sv
// Purpose: Self-checking bench for the timer block
// Assumes: Register access over AXI4-Lite, one clock
// Notes:   Expected reads are queued and matched in order
`include "tcco_defs.vh"
module tcco_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        pta = 1'b1;
  logic        ptb = 1'b1;
  logic [31:0] rs = 32'hfc0d;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  wire         awready, wready, bvalid, arready, rvalid;
  wire         out_a, out_b, irq_a, irq_b, pin;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0, pa = -1, pb = -1, per = 0;
  int          ia = 0, ib = 0, tca = 0, tcb = 0, e, n0, w;

  // Free-running 20 MHz clock
  always #25 clk = ~clk;

  tcco_timer uut (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_input_pin(pin), .timer_out_a(out_a), .timer_out_b(out_b),
    .match_a_irq(irq_a), .match_b_irq(irq_b));
  tcco_event_src ev (.clk(clk), .pin(pin));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Compare and count
  task automatic chk(input string nm, input [33:0] got, input [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One write transfer, response checked by the monitor
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] r = 2'h0);
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // One read transfer, data checked by the monitor
  task automatic rd(input [11:0] a, input [31:0] d, input [1:0] r = 2'h0);
    @(posedge clk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic conclude;
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Monitor: answers against notes, match gaps, output changes
  always @(posedge clk) begin
    cyc++;
    if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk("bresp", bresp, bq.pop_front());
    if (irq_a) begin
      if (pa >= 0 && per > 0) chk("gap_a", cyc - pa, per);
      pa = cyc;
      ia++;
    end
    if (irq_b) begin
      if (pb >= 0 && per > 0) chk("gap_b", cyc - pb, per);
      pb = cyc;
      ib++;
    end
    if (out_a !== pta) tca++;
    if (out_b !== ptb) tcb++;
    pta = out_a;
    ptb = out_b;
  end

  // Watchdog
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    conclude;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`TCCO_OFF_CTRL, 32'h0);
    rd(`TCCO_OFF_OUTCTL, 32'h0);
    rd(`TCCO_OFF_PRESC, 32'h7);
    rd(`TCCO_OFF_CMPB, 32'hffff);
    wr(`TCCO_OFF_COUNT, 32'h1234);
    rd(`TCCO_OFF_COUNT, 32'h0);
    wr(12'h020, 32'h1, 2'h2);
    rd(12'h020, 32'h0, 2'h2);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      wr(`TCCO_OFF_CMPA, {16'h0, rs[15:0]});
      rd(`TCCO_OFF_CMPA, {16'h0, rs[15:0]});
    end
    for (int v = 0; v < 4; v++) begin
      wr(`TCCO_OFF_OUTCTL, {v[1], 1'b0, v[0], 1'b0});
      repeat (2) @(posedge clk);
      chk("fix_a", out_a, !v[0]);
      chk("fix_b", out_b, !v[1]);
    end
    // event counting and capture per edge mode
    for (int m = 0; m < 3; m++) begin
      wr(`TCCO_OFF_CTRL, 32'h0);
      rd(`TCCO_OFF_COUNT, 32'h0);
      wr(`TCCO_OFF_CTRL, m * 32 + 3);
      if (m == 0) wr(`TCCO_OFF_STATUS, 32'h7);
      if (m == 0) rd(`TCCO_OFF_STATUS, 32'h0);
      e = 0;
      for (int s = 1; s <= 6; s++) begin
        ev.set_level(s[0], 8);
        e += (m == 2) || (m == 0 && s[0]) || (m == 1 && !s[0]);
        if (s == 3) wr(`TCCO_OFF_CTRL, m * 32 + 3);
        if (m == 0 && s == 1) rd(`TCCO_OFF_STATUS, 32'h6);
        rd(`TCCO_OFF_COUNT, e ? e - 1 : 0);
        if (e > 0) rd(`TCCO_OFF_CAPT, e > 1 ? e - 2 : 0);
      end
    end
    wr(`TCCO_OFF_CTRL, 32'h0);
    wr(`TCCO_OFF_CMPA, 32'h3);
    wr(`TCCO_OFF_CMPB, 32'h9);
    per = 80;
    for (int lv = 0; lv < 2; lv++) begin
      wr(`TCCO_OFF_OUTCTL, lv ? 32'hf : 32'h5);
      wr(`TCCO_OFF_CTRL, 32'h11);
      pa = -1;
      pb = -1;
      ia = 0;
      ib = 0;
      tca = 0;
      tcb = 0;
      for (int k = 0; k < 400 && ia < 3; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("toggles_a", tca, ia);
      chk("toggles_b", tcb, ib);
      wr(`TCCO_OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk("stop_a", out_a, !lv);
      chk("stop_b", out_b, !lv);
    end
    wr(`TCCO_OFF_OUTCTL, 32'h11);
    pa = -1;
    pb = -1;
    wr(`TCCO_OFF_CTRL, 32'h11);
    n0 = ia;
    for (int k = 0; k < 400 && ia == n0; k++) @(posedge clk);
    wr(`TCCO_OFF_OUTCTL, 32'h51);
    repeat (2) @(posedge clk);
    chk("shot_on", out_a, 1'b0);
    n0 = ia;
    for (int k = 0; k < 400 && ia == n0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("shot_off", out_a, 1'b1);
    wr(`TCCO_OFF_CTRL, 32'h0);
    // PPG on output a: width from compare a, period from compare b
    wr(`TCCO_OFF_OUTCTL, 32'h5);
    pa = -1;
    pb = -1;
    wr(`TCCO_OFF_CTRL, 32'h1d);
    for (w = 0; w < 400 && out_a !== 1'b0; w++) @(posedge clk);
    for (w = 0; w < 400 && out_a !== 1'b1; w++) @(posedge clk);
    for (w = 0; w < 400 && out_a !== 1'b0; w++) @(posedge clk);
    chk("ppg_width", w, 3 * 8);
    while (w < 800 && out_a !== 1'b1) begin
      @(posedge clk);
      w++;
    end
    chk("ppg_period", w, (9 + 1) * 8);
    wr(`TCCO_OFF_CTRL, 32'h0);
    wr(`TCCO_OFF_PRESC, 32'h0);
    wr(`TCCO_OFF_STATUS, 32'h7);
    per = 65536;
    pa = -1;
    pb = -1;
    wr(`TCCO_OFF_OUTCTL, 32'h15);
    wr(`TCCO_OFF_CTRL, 32'h9);
    tcb = 0;
    repeat (65600) @(posedge clk);
    chk("pwm_b_edges", tcb, 3);
    rd(`TCCO_OFF_STATUS, 32'h5);
    wr(`TCCO_OFF_STATUS, 32'h1);
    rd(`TCCO_OFF_STATUS, 32'h4);
    wr(`TCCO_OFF_CTRL, 32'h0);
    conclude;
  end
endmodule // tcco_timer_tb_top
